// >>> bench/rmsl_loader_props.sv
// Port checker for the reset mode select loader.
`timescale 1ns/1ns
`include "rmsl_consts.svh"
module rmsl_loader_props
  import rmsl_pkg::*;
(
  input wire logic          aclk,             // Clock.
  input wire logic          aresetn,          // Reset, low.
  input wire logic [2:0]    mode_select_pins, // Straps.
  input wire logic          fetch_req,        // Read request.
  input wire logic [23:0]   fetch_addr,       // Read address.
  input wire logic          fetch_ack,        // Read taken.
  input wire logic [7:0]    fetch_data,       // Read byte.
  input wire logic [1:0]    bus_mode,         // Bus mode.
  input wire rmsl_op_mode_t op_mode,          // Operation mode.
  input wire logic          seq_done,         // Sequence done.
  input wire logic          flash_we_ok,      // Write permit.
  input wire logic          mode_error        // Error flag.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] cap;
  logic       got;
  // Copy of the fetched byte, so loaded modes can be tied to their cause.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap <= 8'h00;
      got <= 1'b0;
    end else if (fetch_req && fetch_ack) begin
      cap <= fetch_data;
      got <= 1'b1;
    end
  end
  property p_addr;
    fetch_req |-> fetch_addr == `RMSL_MODE_DATA_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("bad fetch address");
  property p_start;
    $rose(aresetn) && mode_select_pins == 3'h3 |-> ##[0:4] fetch_req;
  endproperty
  a_start: assert property (p_start) else $error("no fetch");
  property p_pre;
    !seq_done |-> bus_mode == 2'h0 && op_mode == RMSL_OP_NORMAL && !flash_we_ok;
  endproperty
  a_pre: assert property (p_pre) else $error("mode early");
  property p_done;
    fetch_req && fetch_ack |-> !seq_done ##[1:3] seq_done;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_keep;
    seq_done |=> seq_done && $stable(bus_mode) && $stable(op_mode);
  endproperty
  a_keep: assert property (p_keep) else $error("mode moved");
  property p_bus;
    seq_done |-> bus_mode == cap[7:6];
  endproperty
  a_bus: assert property (p_bus) else $error("bus mode");
  property p_op;
    seq_done && got && mode_select_pins == 3'h3
      |-> op_mode == (cap[5] ? 2'h2 : {1'b0, cap[4]});
  endproperty
  a_op: assert property (p_op) else $error("op mode");
  property p_par;
    seq_done && mode_select_pins == 3'h7 |-> op_mode == RMSL_OP_FLASH;
  endproperty
  a_par: assert property (p_par) else $error("flash mode");
  property p_we;
    flash_we_ok |-> seq_done && mode_select_pins == 3'h6;
  endproperty
  a_we: assert property (p_we) else $error("write permit");
  property p_err;
    seq_done && (cap[7:6] != 2'h0 ||
      !(mode_select_pins inside {3'h3, 3'h6, 3'h7})) |-> mode_error;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok;
    seq_done && got && cap[7:6] == 2'h0 && mode_select_pins == 3'h3
      |-> !mode_error;
  endproperty
  a_ok: assert property (p_ok) else $error("false error");
  c_done: cover property ($rose(seq_done));
  c_we: cover property (flash_we_ok);
  c_err: cover property (seq_done && mode_error);
endmodule : rmsl_loader_props
bind rmsl_loader rmsl_loader_props u_props (
  .aclk, .aresetn, .mode_select_pins, .fetch_req, .fetch_addr, .fetch_ack,
  .fetch_data, .bus_mode, .op_mode, .seq_done, .flash_we_ok, .mode_error
);

// >>> bench/rmsl_mem_model.sv
// Memory and sequencer model that answers the mode byte fetch.
`timescale 1ns/1ns
`include "rmsl_consts.svh"
module rmsl_mem_model (
  input  wire logic        aclk,       // Clock.
  input  wire logic        fetch_req,  // Read request.
  input  wire logic [23:0] fetch_addr, // Read address.
  input  wire logic [7:0]  mode_byte,  // Byte stored at the mode address.
  input  wire logic [7:0]  wait_cyc,   // Answer delay; FF never answers.
  output logic             fetch_ack,  // Read taken.
  output logic [7:0]       fetch_data  // Read byte.
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    fetch_ack = 1'b0;
    fetch_data = 8'hA5;
  end
  // Data toggles outside the ack so a stale byte can never look valid.
  always @(posedge aclk) begin
    fetch_ack <= 1'b0;
    fetch_data <= ~fetch_data;
    if (fetch_req && !fetch_ack && fetch_addr == `RMSL_MODE_DATA_ADDR) begin
      cnt <= cnt + 8'h01;
      if (wait_cyc != 8'hFF && cnt >= wait_cyc) begin
        fetch_ack <= 1'b1;
        fetch_data <= mode_byte;
        cnt <= 8'h00;
      end
    end else begin
      cnt <= 8'h00;
    end
  end
endmodule : rmsl_mem_model

// >>> bench/test_rmsl_loader.sv
// Self-checking bench for the reset mode select loader.
`timescale 1ns/1ns
`include "rmsl_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module test_rmsl_loader
  import rmsl_pkg::*;
;
  logic          aclk, aresetn, fetch_req, fetch_ack, seq_done;
  logic          flash_we_ok, mode_error, unlock_in;
  logic [2:0]    pins;
  logic [23:0]   fetch_addr;
  logic [7:0]    fetch_data, mode_byte, wait_cyc;
  logic [1:0]    bus_mode, bresp, rresp, r;
  rmsl_op_mode_t op_mode;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata, d;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  int            miscompares, check_count, cycles;
  rmsl_loader uut (.aclk, .aresetn, .mode_select_pins(pins), .fetch_req,
    .fetch_addr, .fetch_ack, .fetch_data, .flash_unlock(unlock_in), .bus_mode,
    .op_mode, .seq_done, .flash_we_ok, .mode_error, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  rmsl_mem_model u_mem (.aclk, .fetch_req, .fetch_addr, .mode_byte,
    .wait_cyc, .fetch_ack, .fetch_data);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // Straps change only inside reset and stay put across the fetch.
  task automatic boot(input logic [2:0] p, input logic [7:0] b, w);
    @(posedge aclk);
    aresetn <= 1'b0;
    pins <= p;
    mode_byte <= b;
    wait_cyc <= w;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 100 && seq_done !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
  endtask : boot
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic t_single();
    boot(3'h3, 8'h00, 8'h00);
    rd(`RMSL_REG_STATUS);
    `CHK(d, 32'h10)
    wr(`RMSL_REG_MODE, 32'hC0);
    `CHK(r, `RMSL_RESP_SLVERR)
    rd(`RMSL_REG_MODE);
    `CHK(d, 32'h300)
    rd(12'h00C);
    `CHK(r, `RMSL_RESP_SLVERR)
  endtask : t_single
  task automatic t_modes();
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      boot(3'h3, {b, b, 4'h0}, 8'(i * 3));
      `CHK(bus_mode, b)
      `CHK(op_mode, (b[1] ? 2'h2 : b))
      `CHK(mode_error, (b != 2'h0))
    end
  endtask : t_modes
  task automatic t_pins();
    logic [2:0] bad [5];
    bad = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    foreach (bad[k]) begin
      boot(bad[k], 8'h00, 8'h00);
      `CHK(mode_error, 1'b1)
    end
    boot(3'h7, 8'h00, 8'h00);
    `CHK(op_mode, RMSL_OP_FLASH)
    boot(3'h6, 8'h00, 8'h00);
    `CHK(flash_we_ok, 1'b0)
    wr(`RMSL_REG_CONTROL, 32'h1);
    `CHK(r, `RMSL_RESP_OKAY)
    repeat (2) @(posedge aclk);
    `CHK(flash_we_ok, 1'b0)
    unlock_in <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(flash_we_ok, 1'b1)
  endtask : t_pins
  task automatic t_timeout();
    boot(3'h3, 8'h00, 8'hFF);
    `CHK(mode_error, 1'b1)
    rd(`RMSL_REG_STATUS);
    `CHK(d, 32'h70)
  endtask : t_timeout
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, unlock_in} = '0;
    {pins, mode_byte, wait_cyc, awaddr, araddr, wdata} = '0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    t_single();
    t_modes();
    t_pins();
    t_timeout();
    report_and_stop();
  end
endmodule : test_rmsl_loader

// >>> hdl/rmsl_consts.svh
// Constants for the reset mode select loader: offsets, fields, resets.
`ifndef RMSL_CONSTS_SVH
`define RMSL_CONSTS_SVH
`define RMSL_MODE_DATA_ADDR   24'hFFFFDF
`define RMSL_BUS_MODE_HI_POS  7
`define RMSL_BUS_MODE_LO_POS  6
`define RMSL_OP_MODE_HI_POS   5
`define RMSL_OP_MODE_LO_POS   4
`define RMSL_RSVD_HI_POS      3
`define RMSL_RSVD_LO_POS      0
`define RMSL_PINS_INT_VECTOR  3'h3
`define RMSL_PINS_SER_FLASH   3'h6
`define RMSL_PINS_PAR_FLASH   3'h7
`define RMSL_BUS_SINGLE_CHIP  2'h0
`define RMSL_HARDWIRED_DATA   8'h00
`define RMSL_REG_STATUS       12'h000
`define RMSL_REG_MODE         12'h004
`define RMSL_REG_CONTROL      12'h008
`define RMSL_RESP_OKAY        2'h0
`define RMSL_RESP_SLVERR      2'h2
`define RMSL_FETCH_TIMEOUT_NS 2000
`define RMSL_CLK_MHZ          20
`define RMSL_FETCH_TIMEOUT_CYC \
  ((`RMSL_FETCH_TIMEOUT_NS * `RMSL_CLK_MHZ) / 1000)
`endif

// >>> hdl/rmsl_loader.sv
// Reset mode select loader: pins, mode-data fetch and mode register.
// Function
// - Bus-mode bits come from the two top bits of the mode byte.
// - Operation mode is derived from pins together with operation-mode bits.
// - Operation mode selects normal run, test program or test function.
// - During vector and mode fetch, bus mode comes from the pins only; the code holds it at single chip (00) instead.
// - After reset sequence, bus mode comes from the loaded bus-mode bits.
// - Pins decode: 011 internal vector, 110 serial flash, 111 parallel flash, others forbidden.
// - All pins high selects parallel-programmer flash mode.
// - Serial flash pins alone never enable flash writes.
// - Mode byte is read from memory address FFFFDF hex.
// - Mode byte is fetched in the reset sequence and latched.
// - Mode register changes only through the reset sequence.
// - Latched mode takes effect only after the reset sequence ends.
// - Bus-mode 00 is single chip; 01, 10 and 11 are inhibited.
// - Flash variants take mode data from hard-wired logic.
// - No external bus function; only single chip operation.
`timescale 1ns/1ns
`include "rmsl_consts.svh"
module rmsl_loader
  import rmsl_pkg::*;
#(
  parameter bit HARDWIRED = 1'b0 // Flash variant: no memory fetch.
) (
  input  wire logic        aclk,          // Machine clock, 20 MHz.
  input  wire logic        aresetn,       // Synchronous reset, low.
  input  wire logic [2:0]  mode_select_pins, // Board mode straps.
  output logic             fetch_req,     // Memory read request.
  output logic [23:0]      fetch_addr,    // Memory read address.
  input  wire logic        fetch_ack,     // Read data valid, same clock.
  input  wire logic [7:0]  fetch_data,    // Read data byte.
  input  wire logic        flash_unlock,  // Extra write condition.
  output logic [1:0]       bus_mode,      // Bus mode in force.
  output rmsl_op_mode_t    op_mode,       // Operation mode in force.
  output logic             seq_done,      // Reset sequence finished.
  output logic             flash_we_ok,   // Flash writes permitted.
  output logic             mode_error,    // Bad pins, bus mode or fetch timeout.
  input  wire logic [11:0] s_axi_awaddr,  // AXI write address.
  input  wire logic        s_axi_awvalid, // AXI write address valid.
  output logic             s_axi_awready, // AXI write address ready.
  input  wire logic [31:0] s_axi_wdata,   // AXI write data.
  input  wire logic [3:0]  s_axi_wstrb,   // AXI write strobes.
  input  wire logic        s_axi_wvalid,  // AXI write data valid.
  output logic             s_axi_wready,  // AXI write data ready.
  output logic [1:0]       s_axi_bresp,   // AXI write response.
  output logic             s_axi_bvalid,  // AXI write response valid.
  input  wire logic        s_axi_bready,  // AXI write response ready.
  input  wire logic [11:0] s_axi_araddr,  // AXI read address.
  input  wire logic        s_axi_arvalid, // AXI read address valid.
  output logic             s_axi_arready, // AXI read address ready.
  output logic [31:0]      s_axi_rdata,   // AXI read data.
  output logic [1:0]       s_axi_rresp,   // AXI read response.
  output logic             s_axi_rvalid,  // AXI read valid.
  input  wire logic        s_axi_rready   // AXI read response ready.
);
  typedef enum logic [1:0] {
    RMSL_ST_FETCH,
    RMSL_ST_WAIT,
    RMSL_ST_RUN
  } rmsl_state_t;

  localparam int TIMEOUT = `RMSL_FETCH_TIMEOUT_CYC;

  rmsl_state_t     state, next_state;
  rmsl_mode_data_t mode_reg, next_mode_reg;
  logic [2:0]      pins_sync;
  rmsl_pin_mode_t  pin_mode;
  rmsl_pin_mode_t  pin_mode_lat, next_pin_mode_lat;
  logic [7:0]      tmo, next_tmo;
  logic            next_fetch_req, next_seq_done, next_flash_we_ok;
  logic            next_mode_error, timeout_err, next_timeout_err;
  logic [1:0]      next_bus_mode;
  rmsl_op_mode_t   next_op_mode;
  logic            unlock, next_unlock;
  logic [1:0]      sync_wait, next_sync_wait;

  initial begin
    if (TIMEOUT < 1 || TIMEOUT > 255) $error("rmsl_loader: bad timeout");
  end

  rmsl_pin_sync #(.WIDTH(3)) u_sync (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .mode_select_pins (mode_select_pins),
    .pins_sync        (pins_sync),
    .pin_mode         (pin_mode)
  );

  // Operation mode from pins plus operation-mode bits.
  function automatic rmsl_op_mode_t op_decode(rmsl_pin_mode_t pm,
                                              logic [1:0] ob);
    rmsl_op_mode_t r;
    r = RMSL_OP_NORMAL;
    if (pm == RMSL_PM_SER_FLASH || pm == RMSL_PM_PAR_FLASH) begin
      r = RMSL_OP_FLASH;
    end else if (ob == 2'h1) begin
      r = RMSL_OP_TEST_PROG;
    end else if (ob[1]) begin
      r = RMSL_OP_TEST_FUNC;
    end
    return r;
  endfunction : op_decode

  // Sequencer: the pins need two edges to settle before being sampled.
  always_comb begin
    next_state        = state;
    next_mode_reg     = mode_reg;
    next_pin_mode_lat = pin_mode_lat;
    next_tmo          = tmo;
    next_fetch_req    = 1'b0;
    next_seq_done     = seq_done;
    next_timeout_err  = timeout_err;
    next_sync_wait    = 2'b00;
    next_bus_mode     = bus_mode;
    next_op_mode      = op_mode;
    next_flash_we_ok  = flash_we_ok;
    next_mode_error   = mode_error;
    unique case (state)
      RMSL_ST_FETCH: begin
        // The synchroniser is cleared in reset, so the straps only show
        // at its output two edges after release; latching earlier would
        // always see a forbidden pattern.
        next_sync_wait = {sync_wait[0], 1'b1};
        if (sync_wait[1]) begin
          next_pin_mode_lat = pin_mode;
          next_bus_mode     = `RMSL_BUS_SINGLE_CHIP;
          if (HARDWIRED) begin
            next_mode_reg = `RMSL_HARDWIRED_DATA;
            next_state    = RMSL_ST_RUN;
          end else begin
            next_fetch_req = 1'b1;
            next_tmo       = 8'(TIMEOUT);
            next_state     = RMSL_ST_WAIT;
          end
        end
      end
      RMSL_ST_WAIT: begin
        next_fetch_req = ~fetch_ack;
        next_tmo       = tmo - 8'h01;
        if (fetch_ack) begin
          next_mode_reg = fetch_data;
          next_state    = RMSL_ST_RUN;
        end else if (tmo == 8'h00) begin
          next_timeout_err = 1'b1;
          next_mode_reg    = `RMSL_HARDWIRED_DATA;
          next_fetch_req   = 1'b0;
          next_state       = RMSL_ST_RUN;
        end
      end
      RMSL_ST_RUN: begin
        // Loaded values only drive the outputs once the sequence is over.
        next_seq_done    = 1'b1;
        next_bus_mode    = mode_reg.bus_mode_bits;
        next_op_mode     = op_decode(pin_mode_lat,
                                     mode_reg.operation_mode_bits);
        // Both the bus unlock bit and the outside condition must hold.
        next_flash_we_ok = (pin_mode_lat == RMSL_PM_SER_FLASH)
                           && unlock && flash_unlock;
        next_mode_error  = (pin_mode_lat == RMSL_PM_FORBIDDEN)
                           || (mode_reg.bus_mode_bits
                               != `RMSL_BUS_SINGLE_CHIP)
                           || timeout_err;
      end
      default: next_state = RMSL_ST_FETCH;
    endcase
    if (!aresetn) begin
      next_state        = RMSL_ST_FETCH;
      next_mode_reg     = '0;
      next_pin_mode_lat = RMSL_PM_FORBIDDEN;
      next_tmo          = '0;
      next_fetch_req    = 1'b0;
      next_seq_done     = 1'b0;
      next_timeout_err  = 1'b0;
      next_sync_wait    = 2'b00;
      next_bus_mode     = `RMSL_BUS_SINGLE_CHIP;
      next_op_mode      = RMSL_OP_NORMAL;
      next_flash_we_ok  = 1'b0;
      next_mode_error   = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    state        <= next_state;
    mode_reg     <= next_mode_reg;
    pin_mode_lat <= next_pin_mode_lat;
    tmo          <= next_tmo;
    fetch_req    <= next_fetch_req;
    fetch_addr   <= `RMSL_MODE_DATA_ADDR;
    seq_done     <= next_seq_done;
    timeout_err  <= next_timeout_err;
    sync_wait    <= next_sync_wait;
    bus_mode     <= next_bus_mode;
    op_mode      <= next_op_mode;
    flash_we_ok  <= next_flash_we_ok;
    mode_error   <= next_mode_error;
  end

  // AXI4-Lite slave. The mode register is read-only over the bus.
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic        w_bit, next_w_bit;
  logic [11:0] aw_addr, next_aw_addr;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_bit   = w_bit;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_unlock  = unlock;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      // Data may arrive before its address, so it waits here.
      next_w_bit  = s_axi_wstrb[0] ? s_axi_wdata[0] : unlock;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (next_aw_held && next_w_held && !next_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (next_aw_addr == `RMSL_REG_CONTROL) ?
                     `RMSL_RESP_OKAY : `RMSL_RESP_SLVERR;
      if (next_aw_addr == `RMSL_REG_CONTROL) begin
        next_unlock = next_w_bit;
      end
    end
    next_awready = !next_aw_held && !s_axi_bvalid;
    next_wready  = !next_w_held && !s_axi_bvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `RMSL_RESP_OKAY;
      unique case (s_axi_araddr)
        `RMSL_REG_STATUS:  next_rdata = {24'h000000, flash_we_ok,
                                         timeout_err, mode_error,
                                         seq_done, op_mode, bus_mode};
        `RMSL_REG_MODE:    next_rdata = {21'h000000, pins_sync,
                                         mode_reg};
        `RMSL_REG_CONTROL: next_rdata = {31'h00000000, unlock};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `RMSL_RESP_SLVERR;
        end
      endcase
    end else begin
      next_arready = !next_rvalid && !s_axi_arready;
    end
    if (!aresetn) begin
      next_aw_held = 1'b0;
      next_aw_addr = 12'h000;
      next_w_held  = 1'b0;
      next_w_bit   = 1'b0;
      next_awready = 1'b0;
      next_wready  = 1'b0;
      next_bvalid  = 1'b0;
      next_bresp   = 2'h0;
      next_unlock  = 1'b0;
      next_arready = 1'b0;
      next_rvalid  = 1'b0;
      next_rdata   = 32'h00000000;
      next_rresp   = 2'h0;
    end
  end

  // Write data lands in unlock only when the address proves to be CONTROL.
  always_ff @(posedge aclk) begin
    aw_held       <= next_aw_held;
    aw_addr       <= next_aw_addr;
    w_held        <= next_w_held;
    w_bit         <= next_w_bit;
    s_axi_awready <= next_awready;
    s_axi_wready  <= next_wready;
    s_axi_bvalid  <= next_bvalid;
    s_axi_bresp   <= next_bresp;
    unlock        <= next_unlock;
    s_axi_arready <= next_arready;
    s_axi_rvalid  <= next_rvalid;
    s_axi_rdata   <= next_rdata;
    s_axi_rresp   <= next_rresp;
  end
endmodule : rmsl_loader

// >>> hdl/rmsl_pin_sync.sv
// Two-stage synchroniser and decoder for the three mode-selection pins.
`timescale 1ns/1ns
`include "rmsl_consts.svh"
module rmsl_pin_sync
  import rmsl_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             aclk,             // Machine clock.
  input  wire logic             aresetn,          // Synchronous reset.
  input  wire logic [WIDTH-1:0] mode_select_pins, // Raw board straps.
  output logic      [WIDTH-1:0] pins_sync,        // Synchronised pins.
  output rmsl_pin_mode_t        pin_mode          // Decoded pin mode.
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_pins_sync;

  initial begin
    if (WIDTH != 3) $error("rmsl_pin_sync: WIDTH must be 3");
  end

  always_comb begin
    next_meta      = mode_select_pins;
    next_pins_sync = meta;
    if (!aresetn) begin
      next_meta      = '0;
      next_pins_sync = '0;
    end
  end

  always_ff @(posedge aclk) begin
    meta      <= next_meta;
    pins_sync <= next_pins_sync;
  end

  // Only the last stage is decoded, never the metastable one.
  always_comb begin
    unique case (pins_sync)
      `RMSL_PINS_INT_VECTOR: pin_mode = RMSL_PM_INT_VECTOR;
      `RMSL_PINS_SER_FLASH:  pin_mode = RMSL_PM_SER_FLASH;
      `RMSL_PINS_PAR_FLASH:  pin_mode = RMSL_PM_PAR_FLASH;
      default:               pin_mode = RMSL_PM_FORBIDDEN;
    endcase
  end
endmodule : rmsl_pin_sync

// >>> hdl/rmsl_pkg.sv
// Types shared by the reset mode select loader files.
package rmsl_pkg;
  typedef enum logic [2:0] {
    RMSL_PM_FORBIDDEN,
    RMSL_PM_INT_VECTOR,
    RMSL_PM_SER_FLASH,
    RMSL_PM_PAR_FLASH
  } rmsl_pin_mode_t;
  typedef enum logic [1:0] {
    RMSL_OP_NORMAL,
    RMSL_OP_TEST_PROG,
    RMSL_OP_TEST_FUNC,
    RMSL_OP_FLASH
  } rmsl_op_mode_t;
  typedef struct packed {
    logic [1:0] bus_mode_bits;
    logic [1:0] operation_mode_bits;
    logic [3:0] reserved;
  } rmsl_mode_data_t;
  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } rmsl_fetch_req_t;
endpackage : rmsl_pkg
